// [design/sfb_pkg.sv]
// Shared constants and types for the serial flash bus front end
package sfb_pkg;

  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_WREN = 8'h06;
  localparam logic [7:0] OPC_WRDI = 8'h04;
  localparam logic [7:0] OPC_RDSR = 8'h05;
  localparam logic [7:0] OPC_WRSR = 8'h01;
  localparam logic [7:0] OPC_PP = 8'h02;
  localparam logic [7:0] OPC_SE = 8'h20;
  localparam logic [7:0] OPC_BE32 = 8'h52;
  localparam logic [7:0] OPC_BE64 = 8'hd8;
  localparam logic [7:0] OPC_CE = 8'h60;
  localparam logic [7:0] OPC_ENTER_SEC = 8'hb1;
  localparam logic [7:0] OPC_EXIT_SEC = 8'hc1;
  localparam logic [7:0] OPC_RD_SCUR = 8'h2b;
  localparam logic [7:0] OPC_WR_SCUR = 8'h2f;
  localparam logic [7:0] OPC_LOCK = 8'h36;
  localparam logic [7:0] OPC_UNLOCK = 8'h39;

  // ----------------------------------------------------------------
  // Field positions, lengths, map and reset values
  // ----------------------------------------------------------------
  localparam int SR_BUSY = 0;
  localparam int SR_WEL = 1;
  localparam int SR_LVL = 2;
  localparam int SR_TB = 6;
  localparam int SC_FACTORY = 0;
  localparam int SC_CUSTOMER = 1;
  localparam logic [2:0] LEN_ONE = 3'h1;
  localparam logic [2:0] LEN_WRSR = 3'h2;
  localparam logic [2:0] LEN_ADDR = 3'h4;
  localparam logic [2:0] LEN_PP = 3'h5;
  localparam logic [2:0] ADDR_LAST_BYTE = 3'h3;
  localparam logic [2:0] BYTES_MAX = 3'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [5:0] BLOCK_LAST = 6'h3f;
  localparam logic [3:0] LVL_ALL = 4'h7;
  localparam logic [6:0] BLOCKS_ALL = 7'h40;
  localparam int UNITS = 94;
  localparam int SECTORS_PER_BLOCK = 16;
  localparam logic [6:0] UNIT_TOP = 7'h10;
  localparam logic [6:0] UNIT_MID = 7'h1f;
  localparam logic [8:0] OTP_ESN_LAST = 9'h00f;
  localparam logic [3:0] RST_LVL = 4'h0;
  localparam logic RST_TB = 1'b0;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    C_NONE = 4'b0000, C_WREN = 4'b0001, C_WRDI = 4'b0010, C_RDSR = 4'b0011,
    C_WRSR = 4'b0100, C_PP = 4'b0101, C_SE = 4'b0110, C_BE32 = 4'b0111,
    C_BE64 = 4'b1000, C_CE = 4'b1001, C_ENTER_SEC = 4'b1010,
    C_EXIT_SEC = 4'b1011, C_RD_SCUR = 4'b1100, C_WR_SCUR = 4'b1101,
    C_LOCK = 4'b1110, C_UNLOCK = 4'b1111
  } sfb_cmd_e;

  typedef enum logic [1:0] {
    PH_CMD = 2'b00, PH_BODY = 2'b01, PH_STANDBY = 2'b10
  } sfb_phase_e;

  typedef enum logic [2:0] {
    OP_PROG = 3'b000, OP_ERASE4K = 3'b001, OP_ERASE32K = 3'b010,
    OP_ERASE64K = 3'b011, OP_ERASE_CHIP = 3'b100, OP_OTP_PROG = 3'b101
  } sfb_op_e;

endpackage : sfb_pkg

// [design/sfb_link.sv]
// Serial engine on the link clock: framing, shifting, pause
`timescale 1ns/100ps
module sfb_link (
  input logic sclk,
  input logic rst,
  input logic cs_n,
  input logic si,
  input logic hold_n,
  input logic quad_io_mode,
  input logic [7:0] status_in,
  input logic [1:0] scur_in,
  output logic so,
  output logic so_oe,
  output sfb_pkg::sfb_cmd_e cmd,
  output logic [23:0] addr,
  output logic [7:0] data,
  output logic cmd_ok,
  output logic frame_tgl
);

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [1:0] c1;
    logic [1:0] c2;
    logic pause;
    sfb_pkg::sfb_phase_e ph;
    logic [2:0] bits;
    logic [2:0] bytes;
    logic [7:0] sh;
    sfb_pkg::sfb_cmd_e cmd;
    logic [23:0] addr;
    logic [7:0] data;
    logic [7:0] tx;
    logic tgl;
  } sfb_link_s;

  sfb_link_s q;
  sfb_link_s next_q;
  logic live;
  logic so_q;
  logic hold_now;
  logic pause_lvl;
  logic [2:0] bits_v;
  logic [2:0] bytes_v;
  sfb_pkg::sfb_phase_e ph_v;
  logic [7:0] sh_v;
  sfb_pkg::sfb_cmd_e dec;

  function automatic logic is_read(input sfb_pkg::sfb_cmd_e c);
    is_read = (c == sfb_pkg::C_RDSR) || (c == sfb_pkg::C_RD_SCUR);
  endfunction : is_read

  function automatic logic has_addr(input sfb_pkg::sfb_cmd_e c);
    has_addr = (c == sfb_pkg::C_PP) || (c == sfb_pkg::C_SE) || (c == sfb_pkg::C_BE32) ||
               (c == sfb_pkg::C_BE64) || (c == sfb_pkg::C_LOCK) || (c == sfb_pkg::C_UNLOCK);
  endfunction : has_addr

  function automatic sfb_pkg::sfb_cmd_e decode(input logic [7:0] b);
    case (b)
      sfb_pkg::OPC_WREN: decode = sfb_pkg::C_WREN;
      sfb_pkg::OPC_WRDI: decode = sfb_pkg::C_WRDI;
      sfb_pkg::OPC_RDSR: decode = sfb_pkg::C_RDSR;
      sfb_pkg::OPC_WRSR: decode = sfb_pkg::C_WRSR;
      sfb_pkg::OPC_PP: decode = sfb_pkg::C_PP;
      sfb_pkg::OPC_SE: decode = sfb_pkg::C_SE;
      sfb_pkg::OPC_BE32: decode = sfb_pkg::C_BE32;
      sfb_pkg::OPC_BE64: decode = sfb_pkg::C_BE64;
      sfb_pkg::OPC_CE: decode = sfb_pkg::C_CE;
      sfb_pkg::OPC_ENTER_SEC: decode = sfb_pkg::C_ENTER_SEC;
      sfb_pkg::OPC_EXIT_SEC: decode = sfb_pkg::C_EXIT_SEC;
      sfb_pkg::OPC_RD_SCUR: decode = sfb_pkg::C_RD_SCUR;
      sfb_pkg::OPC_WR_SCUR: decode = sfb_pkg::C_WR_SCUR;
      sfb_pkg::OPC_LOCK: decode = sfb_pkg::C_LOCK;
      sfb_pkg::OPC_UNLOCK: decode = sfb_pkg::C_UNLOCK;
      default: decode = sfb_pkg::C_NONE;
    endcase
  endfunction : decode

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  assign hold_now = ~hold_n & ~quad_io_mode;  // [RL17] [RL21]

  always_comb begin
    next_q = q;
    next_q.s1 = status_in;
    next_q.s2 = q.s1;
    next_q.c1 = scur_in;
    next_q.c2 = q.c1;
    next_q.pause = hold_now;
    // First edge of a frame restarts counting without an async clear
    bits_v = live ? q.bits : 3'h0;
    bytes_v = live ? q.bytes : 3'h0;
    ph_v = live ? q.ph : sfb_pkg::PH_CMD;
    sh_v = {q.sh[6:0], si};
    dec = decode(sh_v);
    if (!hold_now) begin  // [RL18]
      if (!live) begin
        next_q.tgl = ~q.tgl;
      end
      next_q.sh = sh_v;  // [RL13]
      next_q.bits = bits_v + 3'h1;
      next_q.bytes = bytes_v;
      next_q.ph = ph_v;
      if (ph_v == sfb_pkg::PH_BODY && is_read(q.cmd)) begin
        next_q.tx = {q.tx[6:0], 1'b0};
      end
      if (bits_v == sfb_pkg::BIT_LAST) begin
        if (bytes_v != sfb_pkg::BYTES_MAX) begin
          next_q.bytes = bytes_v + 3'h1;
        end
        if (ph_v == sfb_pkg::PH_CMD) begin
          next_q.cmd = dec;
          next_q.ph = (dec == sfb_pkg::C_NONE) ? sfb_pkg::PH_STANDBY  // [RL11]
                                               : sfb_pkg::PH_BODY;    // [RL12]
          next_q.tx = (dec == sfb_pkg::C_RDSR) ? q.s2 : {6'h00, q.c2};
        end else if (ph_v == sfb_pkg::PH_BODY) begin
          if (is_read(q.cmd)) begin
            // Reads repeat until the host deselects
            next_q.tx = (q.cmd == sfb_pkg::C_RDSR) ? q.s2 : {6'h00, q.c2};  // [RL14]
          end else if (has_addr(q.cmd) && bytes_v <= sfb_pkg::ADDR_LAST_BYTE) begin
            next_q.addr = {q.addr[15:0], sh_v};
          end else begin
            next_q.data = sh_v;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Deselect, also during a pause, drops the frame  [RL20]
  always_ff @(posedge sclk or posedge cs_n or posedge rst) begin
    if (rst || cs_n) begin
      live <= 1'b0;
    end else if (!hold_now) begin
      live <= 1'b1;
    end
  end

  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      so_q <= 1'b0;
    end else if (!q.pause) begin
      so_q <= q.tx[7];  // [RL13]
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Pause level follows the pin only while the clock is low
  assign pause_lvl = sclk ? q.pause : hold_now;  // [RL17]
  assign so = so_q;
  assign so_oe = ~cs_n & live & (q.ph == sfb_pkg::PH_BODY) & is_read(q.cmd)
                 & ~pause_lvl;  // [RL11] [RL18]
  assign cmd_ok = (q.bits == 3'h0) && (q.ph == sfb_pkg::PH_BODY) && !is_read(q.cmd) &&
                  ((q.cmd == sfb_pkg::C_PP) ? (q.bytes >= sfb_pkg::LEN_PP) :
                   (q.cmd == sfb_pkg::C_WRSR) ? (q.bytes == sfb_pkg::LEN_WRSR) :
                   has_addr(q.cmd) ? (q.bytes == sfb_pkg::LEN_ADDR) :
                   (q.bytes == sfb_pkg::LEN_ONE));  // [RL15]
  assign cmd = q.cmd;
  assign addr = q.addr;
  assign data = q.data;
  assign frame_tgl = q.tgl;

endmodule : sfb_link

// [design/sfb_frontend.sv]
// Serial flash bus front end: command commit, protection, secured area
// What this block does
// [RL1] Bottom-start set: level n of 1..6 protects 2^(n-1) blocks from block 0
// [RL2] Whole-chip erase runs only when every protect-level bit is zero
// [RL3] Program goes to the secured area only while secured mode is on
// [RL4] Security bit 0 reports the factory lock of the secured area
// [RL5] Security-register write sets security bit 1, the customer lock
// [RL6] Set lock indications never clear and block further secured-area changes; the factory lock here blocks only offsets 000-00F
// [RL7] Secured mode blocks every main-array access
// [RL8] Secured offsets 000-00F hold serial number, 010-1FF customer; upper bits ignored
// [RL9] 24-bit map: 4KB sectors, 32KB and 64KB blocks, top at 3FFFFF
// [RL10] Individual mode: edge blocks lock per sector, others per whole block
// [RL11] Unknown opcode gives standby with output released until next select
// [RL12] Known opcode keeps the engine active until deselect
// [RL13] Sample on rising clock, shift out on falling; modes 0 and 3
// [RL14] Reads may end after any output bit without error
// [RL15] Write-type commands must end on a byte boundary or are dropped
// [RL16] Array accesses are ignored while the core is busy
// [RL17] Pause starts and ends on the hold pin only while clock is low
// [RL18] During pause the output floats and clock and input are ignored
// [RL19] Pause never halts a running status write, program or erase
// [RL20] Deselect during pause resets the interface logic
// [RL21] Pause is disabled in quad mode
// [RL22] Host should poll status before issuing a command
// [RL23] Bottom-start clear: level n of 1..6 protects 2^(n-1) blocks from block 63
`timescale 1ns/100ps
module sfb_frontend (
  input logic clk,
  input logic rst,
  input logic sclk,
  input logic cs_n,
  input logic si,
  output logic so,
  output logic so_oe,
  input logic hold_n,
  input logic quad_io_mode,
  input logic individual_lock_mode,
  input logic factory_locked,
  input logic cust_locked_nv,
  input logic core_busy,
  output logic op_start,
  output sfb_pkg::sfb_op_e op_kind,
  output logic [23:0] op_addr,
  output logic [7:0] op_data,
  output logic cust_lock_burn,
  output logic secured_mode,
  output logic write_enable_latch,
  output logic bottom_start_select,
  output logic protect_level_bit3,
  output logic protect_level_bit2,
  output logic protect_level_bit1,
  output logic protect_level_bit0
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs1;
    logic cs2;
    logic cs3;
    logic tg1;
    logic tg2;
    logic seen;
    logic [3:0] lvl;
    logic tb;
    logic wel;
    logic secured;
    logic cust_lock;
    logic [sfb_pkg::UNITS-1:0] locks;
    logic op_start;
    sfb_pkg::sfb_op_e op_kind;
    logic [23:0] op_addr;
    logic [7:0] op_data;
    logic burn;
  } sfb_front_s;

  sfb_front_s q;
  sfb_front_s next_q;

  sfb_pkg::sfb_cmd_e link_cmd;
  logic [23:0] link_addr;
  logic [7:0] link_data;
  logic link_ok;
  logic link_tgl;
  logic [7:0] status_byte;
  logic [1:0] scur_bits;

  logic [5:0] blk;
  logic [3:0] sec;
  logic edge_block;
  logic [6:0] unit;
  logic unit_hit;
  logic any_sector;
  logic bp_hit;
  logic prot_sector;
  logic prot_block;
  logic chip_ok;
  logic [8:0] otp_off;
  logic otp_ok;
  logic can_write;
  logic array_ok;
  logic commit;

  // ----------------------------------------------------------------
  // Link engine
  // ----------------------------------------------------------------
  sfb_link u_link (
    .sclk(sclk),
    .rst(rst),
    .cs_n(cs_n),
    .si(si),
    .hold_n(hold_n),
    .quad_io_mode(quad_io_mode),
    .status_in(status_byte),
    .scur_in(scur_bits),
    .so(so),
    .so_oe(so_oe),
    .cmd(link_cmd),
    .addr(link_addr),
    .data(link_data),
    .cmd_ok(link_ok),
    .frame_tgl(link_tgl)
  );

  // Busy comes straight from the core, so a pause cannot stall it  [RL19]
  always_comb begin
    status_byte = 8'h00;
    status_byte[sfb_pkg::SR_BUSY] = core_busy;
    status_byte[sfb_pkg::SR_WEL] = q.wel;
    status_byte[sfb_pkg::SR_LVL +: 4] = q.lvl;
    status_byte[sfb_pkg::SR_TB] = q.tb;
    scur_bits = 2'h0;
    scur_bits[sfb_pkg::SC_FACTORY] = factory_locked;  // [RL4]
    scur_bits[sfb_pkg::SC_CUSTOMER] = q.cust_lock;  // [RL5]
  end

  // ----------------------------------------------------------------
  // Block-protect decode
  // ----------------------------------------------------------------
  function automatic logic level_hit(input logic [5:0] b, input logic [3:0] lvl,
                                     input logic tb);
    logic [6:0] cnt;
    cnt = 7'h01 << 3'(lvl[2:0] - 3'h1);
    if (lvl == 4'h0) begin
      level_hit = 1'b0;
    end else if (lvl >= sfb_pkg::LVL_ALL) begin
      level_hit = 1'b1;
    end else if (tb) begin
      level_hit = {1'b0, b} < cnt;  // [RL1]
    end else begin
      level_hit = {1'b0, b} >= (sfb_pkg::BLOCKS_ALL - cnt);  // [RL23]
    end
  endfunction : level_hit

  // ----------------------------------------------------------------
  // Address map and individual locks
  // ----------------------------------------------------------------
  // Bits 23:22 lie beyond the top of the array and are ignored
  assign blk = link_addr[21:16];  // [RL9]
  assign sec = link_addr[15:12];  // [RL9]
  assign edge_block = (blk == 6'h00) || (blk == sfb_pkg::BLOCK_LAST);

  always_comb begin
    if (blk == 6'h00) begin
      unit = {3'h0, sec};  // [RL10]
    end else if (blk == sfb_pkg::BLOCK_LAST) begin
      unit = sfb_pkg::UNIT_TOP + {3'h0, sec};  // [RL10]
    end else begin
      unit = {1'b0, blk} + sfb_pkg::UNIT_MID;  // [RL10]
    end
  end

  assign unit_hit = q.locks[unit];
  // Erasing a 32KB half of an edge block checks all 16 of its sectors
  assign any_sector = (blk == 6'h00) ? |q.locks[0 +: sfb_pkg::SECTORS_PER_BLOCK]
                    : |q.locks[sfb_pkg::UNIT_TOP +: sfb_pkg::SECTORS_PER_BLOCK];
  assign bp_hit = level_hit(blk, q.lvl, q.tb);
  assign prot_sector = individual_lock_mode ? unit_hit : bp_hit;
  assign prot_block = individual_lock_mode ? (edge_block ? any_sector : unit_hit) : bp_hit;
  assign chip_ok = (q.lvl == 4'h0) && (!individual_lock_mode || q.locks == '0);  // [RL2]

  // ----------------------------------------------------------------
  // Secured area
  // ----------------------------------------------------------------
  assign otp_off = link_addr[8:0];  // [RL8]
  assign otp_ok = (otp_off <= sfb_pkg::OTP_ESN_LAST) ? !(factory_locked || q.cust_lock)
                                                     : !q.cust_lock;  // [RL6] [RL8]

  // ----------------------------------------------------------------
  // Commit on deselect
  // ----------------------------------------------------------------
  assign can_write = q.wel && !core_busy;  // [RL16]
  assign array_ok = can_write && !q.secured;  // [RL7]
  // Link words are still while the select is high, so they are taken
  // once the synchronised rising select is seen; a frame toggle keeps an
  // edgeless select pulse from replaying the previous command
  assign commit = q.cs2 && !q.cs3 && (q.tg2 != q.seen) && link_ok;  // [RL15]

  always_comb begin
    next_q = q;
    next_q.cs1 = cs_n;
    next_q.cs2 = q.cs1;
    next_q.cs3 = q.cs2;
    next_q.tg1 = link_tgl;
    next_q.tg2 = q.tg1;
    next_q.op_start = 1'b0;
    next_q.burn = 1'b0;
    next_q.cust_lock = q.cust_lock | cust_locked_nv;  // [RL6]
    if (q.cs2 && !q.cs3) begin
      next_q.seen = q.tg2;
    end
    if (commit) begin
      case (link_cmd)
        sfb_pkg::C_WREN: begin
          next_q.wel = 1'b1;
        end
        sfb_pkg::C_WRDI: begin
          next_q.wel = 1'b0;
        end
        sfb_pkg::C_WRSR: begin
          if (can_write) begin
            next_q.lvl = link_data[sfb_pkg::SR_LVL +: 4];  // [RL1] [RL23]
            next_q.tb = link_data[sfb_pkg::SR_TB];
            next_q.wel = 1'b0;
          end
        end
        sfb_pkg::C_ENTER_SEC: begin
          next_q.secured = 1'b1;  // [RL3]
        end
        sfb_pkg::C_EXIT_SEC: begin
          next_q.secured = 1'b0;  // [RL3]
        end
        sfb_pkg::C_WR_SCUR: begin
          if (can_write) begin
            next_q.cust_lock = 1'b1;  // [RL5]
            next_q.burn = 1'b1;
            next_q.wel = 1'b0;
          end
        end
        sfb_pkg::C_PP: begin
          if (can_write && q.secured && otp_ok) begin
            next_q.op_start = 1'b1;  // [RL3]
            next_q.op_kind = sfb_pkg::OP_OTP_PROG;
            next_q.op_addr = {15'h0000, otp_off};
            next_q.op_data = link_data;
            next_q.wel = 1'b0;
          end else if (array_ok && !prot_sector) begin
            next_q.op_start = 1'b1;
            next_q.op_kind = sfb_pkg::OP_PROG;
            next_q.op_addr = {2'h0, link_addr[21:0]};
            next_q.op_data = link_data;
            next_q.wel = 1'b0;
          end
        end
        sfb_pkg::C_SE: begin
          if (array_ok && !prot_sector) begin
            next_q.op_start = 1'b1;
            next_q.op_kind = sfb_pkg::OP_ERASE4K;
            next_q.op_addr = {2'h0, link_addr[21:12], 12'h000};  // [RL9]
            next_q.wel = 1'b0;
          end
        end
        sfb_pkg::C_BE32: begin
          if (array_ok && !prot_block) begin
            next_q.op_start = 1'b1;
            next_q.op_kind = sfb_pkg::OP_ERASE32K;
            next_q.op_addr = {2'h0, link_addr[21:15], 15'h0000};  // [RL9]
            next_q.wel = 1'b0;
          end
        end
        sfb_pkg::C_BE64: begin
          if (array_ok && !prot_block) begin
            next_q.op_start = 1'b1;
            next_q.op_kind = sfb_pkg::OP_ERASE64K;
            next_q.op_addr = {2'h0, blk, 16'h0000};  // [RL9]
            next_q.wel = 1'b0;
          end
        end
        sfb_pkg::C_CE: begin
          if (array_ok && chip_ok) begin
            next_q.op_start = 1'b1;  // [RL2]
            next_q.op_kind = sfb_pkg::OP_ERASE_CHIP;
            next_q.op_addr = 24'h000000;
            next_q.wel = 1'b0;
          end
        end
        sfb_pkg::C_LOCK: begin
          if (individual_lock_mode && can_write) begin
            next_q.locks[unit] = 1'b1;  // [RL10]
          end
        end
        sfb_pkg::C_UNLOCK: begin
          if (individual_lock_mode && can_write) begin
            next_q.locks[unit] = 1'b0;  // [RL10]
          end
        end
        default: begin
          next_q.seen = q.tg2;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.cs1 <= 1'b1;
      q.cs2 <= 1'b1;
      q.cs3 <= 1'b1;
      q.lvl <= sfb_pkg::RST_LVL;
      q.tb <= sfb_pkg::RST_TB;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign op_start = q.op_start;
  assign op_kind = q.op_kind;
  assign op_addr = q.op_addr;
  assign op_data = q.op_data;
  assign cust_lock_burn = q.burn;
  assign secured_mode = q.secured;
  assign write_enable_latch = q.wel;
  assign bottom_start_select = q.tb;
  assign protect_level_bit3 = q.lvl[3];
  assign protect_level_bit2 = q.lvl[2];
  assign protect_level_bit1 = q.lvl[1];
  assign protect_level_bit0 = q.lvl[0];

endmodule : sfb_frontend

// [verif/sfb_props.sv]
// Property checker for the serial flash bus front end
`timescale 1ns/100ps
module sfb_props (
  input logic clk,
  input logic rst,
  input logic sclk,
  input logic cs_n,
  input logic hold_n,
  input logic quad_io_mode,
  input logic factory_locked,
  input logic core_busy,
  input logic so_oe,
  input logic op_start,
  input sfb_pkg::sfb_op_e op_kind,
  input logic [23:0] op_addr,
  input logic secured_mode,
  input logic bottom_start_select,
  input logic protect_level_bit3,
  input logic protect_level_bit2,
  input logic protect_level_bit1,
  input logic protect_level_bit0
);
  logic [3:0] lvl;
  assign lvl = {protect_level_bit3, protect_level_bit2, protect_level_bit1, protect_level_bit0};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_deselect_quiet: assert property (cs_n |-> !so_oe)
    else $error("Output driven while deselected");
  a_pause_quiet: assert property (!hold_n && $past(hold_n) == 1'b0 && !sclk && !quad_io_mode
    |-> !so_oe) else $error("Output driven during pause");
  a_chip_gate: assert property (op_start && op_kind == sfb_pkg::OP_ERASE_CHIP |-> lvl == 4'h0)
    else $error("Chip erase with protect level set");
  a_secured_array: assert property (op_start && secured_mode |-> op_kind == sfb_pkg::OP_OTP_PROG)
    else $error("Array access in secured mode");
  a_otp_in_mode: assert property (op_start && op_kind == sfb_pkg::OP_OTP_PROG
    |-> secured_mode && op_addr[23:9] == 15'h0) else $error("Bad secured program");
  a_factory_esn: assert property (op_start && op_kind == sfb_pkg::OP_OTP_PROG && factory_locked
    |-> op_addr[8:0] > sfb_pkg::OTP_ESN_LAST) else $error("Locked serial changed");
  a_busy_blocks: assert property (op_start |-> !$past(core_busy))
    else $error("Operation started while busy");
  a_level_one: assert property (op_start && op_kind == sfb_pkg::OP_PROG && lvl == 4'h1
    |-> op_addr[21:16] != (bottom_start_select ? 6'h00 : 6'h3f))
    else $error("Program into protected block");
  a_sector_align: assert property (op_start && op_kind == sfb_pkg::OP_ERASE4K
    |-> op_addr[11:0] == 12'h000) else $error("Sector base misaligned");
endmodule : sfb_props

bind sfb_frontend sfb_props u_props (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
  .hold_n(hold_n), .quad_io_mode(quad_io_mode), .factory_locked(factory_locked),
  .core_busy(core_busy), .so_oe(so_oe), .op_start(op_start), .op_kind(op_kind),
  .op_addr(op_addr), .secured_mode(secured_mode), .bottom_start_select(bottom_start_select),
  .protect_level_bit3(protect_level_bit3), .protect_level_bit2(protect_level_bit2),
  .protect_level_bit1(protect_level_bit1), .protect_level_bit0(protect_level_bit0));

// [verif/sfb_host.sv]
// Host controller model driving the link in clock mode 0
`timescale 1ns/100ps
module sfb_host (
  output logic sclk,
  output logic cs_n,
  output logic si,
  output logic hold_n,
  input logic so,
  input logic so_oe
);
  logic oe_seen;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task automatic frame(input logic [39:0] d, input int nb, input int hold_at,
                       output logic [7:0] rx);
    rx = 8'h00;
    oe_seen = 1'b0;
    cs_n = 1'b0;
    #16;
    for (int i = 0; i < nb; i++) begin
      si = d[39 - i];
      if (i == hold_at) begin
        hold_n = 1'b0; // Clock is low
        repeat (6) begin
          #16;
          sclk = ~sclk;
          si = ~si;
        end
        #16;
        hold_n = 1'b1;
        si = d[39 - i];
      end
      #16;
      sclk = 1'b1;
      rx = {rx[6:0], so};
      oe_seen = oe_seen | so_oe;
      #16;
      sclk = 1'b0;
    end
    #16;
    cs_n = 1'b1; // Deselect after nb bits, whole byte or not; writes count only on whole bytes
    si = ~si;
    #300; // Gap covers the commit
  endtask : frame
endmodule : sfb_host

// [verif/sfb_frontend_tb.sv]
// Self-checking bench for the serial flash bus front end
`timescale 1ns/100ps
module sfb_frontend_tb;
  logic clk, rst, quad_io_mode, individual_lock_mode, factory_locked, cust_locked_nv;
  logic core_busy, sclk, cs_n, si, so, so_oe, hold_n, op_start, secured_mode, wel;
  logic bss, p3, p2, p1, p0, t, e;
  logic [3:0] l;
  logic [23:0] a, op_addr;
  logic [7:0] op_data, rx;
  sfb_pkg::sfb_op_e op_kind;
  int miscompares = 0, samples_checked = 0, ops = 0, n0;
  logic [29:0] rows [6] = '{{1'b1, 4'h1, 24'h000010, 1'b0}, {1'b1, 4'h1, 24'h010000, 1'b1},
    {1'b0, 4'h1, 24'h3f0000, 1'b0}, {1'b0, 4'h6, 24'h1f0000, 1'b1},
    {1'b1, 4'hf, 24'h200000, 1'b0}, {1'b0, 4'h0, 24'h3fffff, 1'b1}};
  sfb_frontend uut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe), .hold_n(hold_n), .quad_io_mode(quad_io_mode),
    .individual_lock_mode(individual_lock_mode), .factory_locked(factory_locked),
    .cust_locked_nv(cust_locked_nv), .core_busy(core_busy), .op_start(op_start),
    .op_kind(op_kind), .op_addr(op_addr), .op_data(op_data), .cust_lock_burn(),
    .secured_mode(secured_mode), .write_enable_latch(wel), .bottom_start_select(bss),
    .protect_level_bit3(p3), .protect_level_bit2(p2), .protect_level_bit1(p1),
    .protect_level_bit0(p0));
  sfb_host u_host (.sclk(sclk), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (op_start === 1'b1) ops <= ops + 1;
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("Checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task automatic cmd(input logic [39:0] d, input int nb);
    u_host.frame(d, nb, -1, rx);
  endtask : cmd
  task automatic wren;
    cmd(40'h0600000000, 8);
  endtask : wren
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    results();
  end
  initial begin
    rst = 1'b1;
    quad_io_mode = 1'b0;
    individual_lock_mode = 1'b0;
    factory_locked = 1'b0;
    cust_locked_nv = 1'b0;
    core_busy = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk({17'h0, secured_mode, wel, bss, p3, p2, p1, p0}, 24'h0);
    for (int i = 0; i < 6; i++) begin
      {t, l, a, e} = rows[i];
      wren();
      cmd({8'h01, 1'b0, t, l, 2'b00, 24'h0}, 16);
      chk({19'h0, bss, p3, p2, p1, p0}, {19'h0, t, l});
      wren();
      n0 = ops;
      cmd({8'h02, a, 8'h5a}, 40);
      chk(24'(ops - n0), {23'h0, e});
      if (e) chk(op_addr, {2'b00, a[21:0]});
      $display("Row %0d done", i);
    end
    wren();
    cmd(40'h0104000000, 16);
    wren();
    n0 = ops;
    cmd(40'h6000000000, 8);
    chk(24'(ops - n0), 24'h0);
    wren();
    cmd(40'h0100000000, 16);
    wren();
    cmd(40'h6000000000, 8);
    chk({21'h0, op_kind}, {21'h0, sfb_pkg::OP_ERASE_CHIP});
    wren();
    cmd(40'h202345ab00, 32);
    chk(op_addr, 24'h234000);
    @(posedge clk) core_busy <= 1'b1;
    wren();
    n0 = ops;
    cmd(40'h0200010033, 40);
    chk(24'(ops - n0), 24'h0);
    @(posedge clk) core_busy <= 1'b0;
    cmd(40'h0400000000, 8);
    cmd(40'h0600000000, 7);
    chk({23'h0, wel}, 24'h0);
    wren();
    u_host.frame(40'h0500000000, 16, 10, rx);
    chk({16'h0, rx}, 24'h000002);
    chk({23'h0, u_host.oe_seen}, 24'h1);
    cmd(40'hff00000000, 16);
    chk({23'h0, u_host.oe_seen}, 24'h0);
    $display("Framing tests done");
    cmd(40'hb100000000, 8);
    chk({23'h0, secured_mode}, 24'h1);
    wren();
    cmd(40'h0212304577, 40);
    chk(op_addr, 24'h000045);
    wren();
    n0 = ops;
    cmd(40'h2001000000, 32);
    chk(24'(ops - n0), 24'h0);
    @(posedge clk) factory_locked <= 1'b1;
    wren();
    cmd(40'h0200000511, 40);
    chk(24'(ops - n0), 24'h0);
    cmd(40'h2b00000000, 16);
    chk(24'(rx), 24'h1);
    wren();
    cmd(40'h2f00000000, 8);
    cmd(40'h2b00000000, 16);
    chk(24'(rx), 24'h3);
    cmd(40'hc100000000, 8);
    chk({23'h0, secured_mode}, 24'h0);
    $display("Secured area tests done");
    results();
  end
endmodule : sfb_frontend_tb
